// ==== hdl/vr_slice_regs.svh ====
/*
  Register indexes, reset values, field positions and timing counts for
  the regulator register slice. Definitions only; included by bare name.
*/
`ifndef VR_SLICE_REGS_SVH
`define VR_SLICE_REGS_SVH

// Bus addresses of the two register spaces
`define BUS_ADDR_MAIN  4'h0
`define BUS_ADDR_POWER 4'hD

// Register indexes
`define IDX_LATENCY    8'h2D
`define IDX_MAX_CODE   8'h30
`define IDX_CUR_CODE   8'h31
`define IDX_CUR_STATE  8'h32
`define IDX_MARGIN     8'h33
`define IDX_SHARED_CFG 8'h34
`define IDX_WR_PTR     8'h35
`define IDX_DBC_CLR    8'h49
`define IDX_CRIT_THR   8'h4A
`define IDX_WARN2_THR  8'h4B
`define IDX_WARN1_THR  8'h4C
`define IDX_WARN2_CNT  8'h4D
`define IDX_WARN1_CNT  8'h4E
`define IDX_DBC_SET    8'h4F
`define IDX_EXTRA_CAP  8'h50
`define IDX_CL_EVENTS  8'h5C

// Reset values
`define RST_LATENCY    8'hCA
`define RST_MAX_CODE   8'hFF
`define RST_ZERO       8'h00
`define RST_WR_PTR     8'h35

// Fields
`define CFG_READY_ZERO_BIT 0
`define ME_MANT_MSB    7
`define ME_MANT_LSB    4
`define ME_EXP_MSB     3
`define ME_EXP_LSB     0
`define ME_SATURATED   8'hFF
`define ME_MANT_WRAP   4'h8
`define CAP_SCALE_MSB  1
`define DEEPEST_STATE  8'h04
`define COUNT_MAX      8'hFF

// Timing: duration fields count ticks of this length
`define MCLK_PERIOD_NS 10
`define TICK_NS        1000
`define TICK_CYCLES    ((`TICK_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ==== hdl/vr_slice_pkg.sv ====
/*
  Types shared by the regulator register slice and its link-side user.
  Widths of the request fields are literal; no constants header is used.
*/
package vr_slice_pkg;

  // Kind of a decoded bus request
  typedef enum logic [1:0] {
    REQ_GET   = 2'h0,
    REQ_SET   = 2'h1,
    REQ_VOLT  = 2'h2,
    REQ_STATE = 2'h3
  } req_kind_type;

  // Acknowledge returned for each request
  typedef enum logic [1:0] {
    ACK_DONE    = 2'h0,
    ACK_REJECT  = 2'h1,
    ACK_NOT_SUP = 2'h2
  } ack_type;

  // Hot alert debounce states
  typedef enum logic [3:0] {
    HOT_IDLE    = 4'h1,
    HOT_WAIT_ON = 4'h2,
    HOT_ACTIVE  = 4'h4,
    HOT_WAIT_OFF = 4'h8
  } hot_state_type;

  typedef struct packed {
    req_kind_type kind;
    logic [3:0]   bus_addr;
    logic [7:0]   index;
    logic [7:0]   data;
  } link_req_type;

  typedef struct packed {
    ack_type    ack;
    logic [7:0] data;
  } link_resp_type;

endpackage

// ==== hdl/vr_reg_slice.sv ====
/*
  Register slice of a multiphase regulator controller: voltage code and
  power state registers, margin offset, shared bus configuration, the
  input power comparators with debounce, warning duration counters and
  the current limit event counter.
  Assumes a link-side decoder that offers one request at a time and
  keeps link_clk running until the answer returns.
*/
// Summary of operation
// - Read-only latency register reads CAh
// - Maximum voltage code register, read/write, FFh
// - Code above maximum answered not supported
// - Current voltage code register updates on accept
// - Power state register holds last programmed state
// - Margin offset is two's complement step count
// - Margin top bit is sign, sign-extended when added
// - Config register steers ready on zero-volt code
// - Write pointer register resets to 35h
// - Durations use mantissa high, exponent low
// - Assert debounce register delays hot alert
// - Hot alert low while power above critical
// - Warning counters accumulate time above threshold
// - Counters clear on read or threshold change
// - Warning counters saturate, never wrap
// - Counters hold in deepest low-power state
// - Capability low bits give amperes per bit
// - Capability upper bits read zero
// - Current limit trips counted, reset 00h
`timescale 1ns/100ps
`default_nettype none
`include "vr_slice_regs.svh"

module vr_reg_slice #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                        mclk,           // Core clock, 100 MHz
  input  wire logic                        rst,            // Async reset, active high
  input  wire logic                        link_clk,       // Serial bus clock
  input  wire logic                        req_valid,      // Decoded request offered
  output logic                             req_ready,      // Slice can take a request
  input  wire vr_slice_pkg::link_req_type  req,            // Request fields
  output logic                             resp_valid,     // Answer pulse, link clock
  output var vr_slice_pkg::link_resp_type  resp,           // Answer fields
  input  wire logic [7:0]                  input_power_sense, // Power reading pins
  input  wire logic                        current_limit_trip, // Trip pin, high
  input  wire logic                        regulator_enable,   // Enable pin
  input  wire logic [1:0]                  cap_scale_strap,    // Scaling strap
  output logic                             hot_alert_n,        // Hot alert, low
  output logic                             regulator_ready,    // Ready output
  output logic [7:0]                       target_voltage_code, // Code plus margin
  output logic                             deepest_low_power_state // In deepest state
);
  import vr_slice_pkg::*;

  // Refuse tick lengths the 16-bit prescaler cannot count
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // Span of a duration field in ticks
  function automatic logic [18:0] me_span(input logic [7:0] v);
    me_span = {15'h0000, v[`ME_MANT_MSB:`ME_MANT_LSB]} << v[`ME_EXP_MSB:`ME_EXP_LSB];
  endfunction

  // Link domain: hold one request, toggle to core, wait for answer
  link_req_type  req_hold_q;
  link_resp_type resp_q;
  logic          busy_q;
  logic          req_tgl_q;
  logic          resp_valid_q;
  logic          ans_s1_q;
  logic          ans_s2_q;
  logic          ans_s3_q;
  logic          ans_seen;

  // Core domain state
  logic          req_s1_q;
  logic          req_s2_q;
  logic          req_s3_q;
  logic          ans_tgl_q;
  link_resp_type ans_q;
  logic [11:0]   pin_s1_q;
  logic [11:0]   pin_s2_q;
  logic [11:0]   pin_s3_q;
  logic [11:0]   pin_q;
  logic          trip_prev_q;
  logic          en_prev_q;
  logic [2:0]    strap_wait_q;
  logic [1:0]    cap_scale_q;
  logic [15:0]   tick_cnt_q;
  logic [7:0]    max_code_q;
  logic [7:0]    cur_code_q;
  logic [7:0]    cur_state_q;
  logic [7:0]    margin_q;
  logic [7:0]    cfg_q;
  logic [7:0]    wr_ptr_q;
  logic [7:0]    dbc_clr_q;
  logic [7:0]    dbc_set_q;
  logic [7:0]    crit_thr_q;
  logic [7:0]    warn_thr_q [2];
  logic [7:0]    warn_cnt_q [2];
  logic [7:0]    cl_events_q;
  logic [7:0]    target_q;
  logic          ready_q;
  hot_state_type hot_q;
  hot_state_type hot_d;
  logic [18:0]   dbc_cnt_q;
  logic          hot_n_q;

  assign ans_seen   = ans_s2_q != ans_s3_q;
  assign req_ready  = !busy_q;
  assign resp_valid = resp_valid_q;
  assign resp       = resp_q;

  // Request is held stable until the answer toggle comes back
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      busy_q     <= 1'b0;
      req_tgl_q  <= 1'b0;
      req_hold_q <= '0;
    end else if (req_valid && !busy_q) begin
      busy_q     <= 1'b1;
      req_tgl_q  <= !req_tgl_q;
      req_hold_q <= req;
    end else if (ans_seen) begin
      busy_q <= 1'b0;
    end
  end

  // Answer toggle crossing; first stage feeds only the second
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      ans_s1_q     <= 1'b0;
      ans_s2_q     <= 1'b0;
      ans_s3_q     <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_q       <= '0;
    end else begin
      ans_s1_q     <= ans_tgl_q;
      ans_s2_q     <= ans_s1_q;
      ans_s3_q     <= ans_s2_q;
      resp_valid_q <= ans_seen;
      if (ans_seen) begin
        resp_q <= ans_q;
      end
    end
  end

  // Core side of the request toggle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Pin inputs move once the last two stages agree.
  // Reading bits settle singly; a stale bit lasts
  // one sample, fine for slow telemetry.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
      pin_s3_q <= 12'h000;
      pin_q    <= 12'h000;
    end else begin
      pin_s1_q <= {input_power_sense, current_limit_trip, regulator_enable, cap_scale_strap};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  logic [7:0] power_now;
  logic       trip_now;
  logic       en_now;
  logic       trip_edge;
  logic       en_rise;
  logic       tick;

  assign power_now = pin_q[11:4];
  assign trip_now  = pin_q[3];
  assign en_now    = pin_q[2];
  assign trip_edge = trip_now && !trip_prev_q;
  assign en_rise   = en_now && !en_prev_q;
  assign tick      = tick_cnt_q == 16'(TICK_CYCLES - 1);

  // Edge history, strap capture after the filter has filled, tick base
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trip_prev_q  <= 1'b0;
      en_prev_q    <= 1'b0;
      strap_wait_q <= 3'h0;
      cap_scale_q  <= 2'h0;
      tick_cnt_q   <= 16'h0000;
    end else begin
      trip_prev_q <= trip_now;
      en_prev_q   <= en_now;
      tick_cnt_q  <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (strap_wait_q != 3'h7) begin
        strap_wait_q <= strap_wait_q + 3'h1;
        cap_scale_q  <= pin_q[`CAP_SCALE_MSB:0];
      end
    end
  end

  // Request decode
  link_req_type rq;
  logic         req_go;
  logic         main_sp;
  logic         pwr_sp;
  logic         is_get;
  logic         is_set;
  logic         rd_hit;
  logic [7:0]   rd_data;
  logic         wr_ok;
  logic         wr_main;
  logic         wr_pwr;
  logic         volt_in;
  logic         volt_ok;
  logic         state_ok;
  logic         zero_cmd;
  logic [1:0]   cnt_clr;
  ack_type      ack;

  assign rq      = req_hold_q;
  assign req_go  = req_s2_q != req_s3_q;
  assign main_sp = rq.bus_addr == `BUS_ADDR_MAIN;
  assign pwr_sp  = rq.bus_addr == `BUS_ADDR_POWER;
  assign is_get  = rq.kind == REQ_GET;
  assign is_set  = rq.kind == REQ_SET;
  assign volt_in = rq.kind == REQ_VOLT && main_sp;

  // Read selection per address space; unknown index misses
  always_comb begin
    rd_hit  = 1'b0;
    rd_data = 8'h00;
    if (main_sp) begin
      rd_hit = 1'b1;
      case (rq.index)
        `IDX_LATENCY:    rd_data = `RST_LATENCY;
        `IDX_MAX_CODE:   rd_data = max_code_q;
        `IDX_CUR_CODE:   rd_data = cur_code_q;
        `IDX_CUR_STATE:  rd_data = cur_state_q;
        `IDX_MARGIN:     rd_data = margin_q;
        `IDX_SHARED_CFG: rd_data = cfg_q;
        `IDX_WR_PTR:     rd_data = wr_ptr_q;
        `IDX_EXTRA_CAP:  rd_data = {6'h00, cap_scale_q};
        `IDX_CL_EVENTS:  rd_data = cl_events_q;
        default:         rd_hit  = 1'b0;
      endcase
    end else if (pwr_sp) begin
      rd_hit = 1'b1;
      case (rq.index)
        `IDX_SHARED_CFG: rd_data = cfg_q;
        `IDX_DBC_CLR:    rd_data = dbc_clr_q;
        `IDX_CRIT_THR:   rd_data = crit_thr_q;
        `IDX_WARN2_THR:  rd_data = warn_thr_q[1];
        `IDX_WARN1_THR:  rd_data = warn_thr_q[0];
        `IDX_WARN2_CNT:  rd_data = warn_cnt_q[1];
        `IDX_WARN1_CNT:  rd_data = warn_cnt_q[0];
        `IDX_DBC_SET:    rd_data = dbc_set_q;
        default:         rd_hit  = 1'b0;
      endcase
    end
  end

  // Writable registers per space; read-only ones refuse writes
  always_comb begin
    wr_ok = 1'b0;
    if (main_sp) begin
      case (rq.index)
        `IDX_MAX_CODE, `IDX_MARGIN, `IDX_SHARED_CFG, `IDX_WR_PTR: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end else if (pwr_sp) begin
      case (rq.index)
        `IDX_SHARED_CFG, `IDX_DBC_CLR, `IDX_CRIT_THR,
        `IDX_WARN2_THR, `IDX_WARN1_THR, `IDX_DBC_SET: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
  end

  assign wr_main  = req_go && is_set && wr_ok && main_sp;
  assign wr_pwr   = req_go && is_set && wr_ok && pwr_sp;
  assign volt_ok  = req_go && volt_in && rq.data <= max_code_q;
  assign state_ok = req_go && rq.kind == REQ_STATE && main_sp;
  assign zero_cmd = volt_ok && rq.data == 8'h00;

  // Reading a counter or changing its threshold clears it
  assign cnt_clr[0] = req_go && pwr_sp && ((is_get && rq.index == `IDX_WARN1_CNT)
                      || (wr_pwr && rq.index == `IDX_WARN1_THR && rq.data != warn_thr_q[0]));
  assign cnt_clr[1] = req_go && pwr_sp && ((is_get && rq.index == `IDX_WARN2_CNT)
                      || (wr_pwr && rq.index == `IDX_WARN2_THR && rq.data != warn_thr_q[1]));

  // Acknowledge: codes above the maximum are not supported
  assign ack = (is_get && rd_hit) || (is_set && wr_ok) || (rq.kind == REQ_STATE && main_sp)
               ? ACK_DONE
               : volt_in ? (rq.data > max_code_q ? ACK_NOT_SUP : ACK_DONE)
               : ACK_REJECT;

  // Answer is registered, then toggled across to the link side
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ans_tgl_q <= 1'b0;
      ans_q     <= '0;
    end else if (req_go) begin
      ans_tgl_q <= !ans_tgl_q;
      ans_q     <= '{ack: ack, data: (is_get && rd_hit) ? rd_data : 8'h00};
    end
  end

  // Main space registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      max_code_q <= `RST_MAX_CODE;
      margin_q   <= `RST_ZERO;
      wr_ptr_q   <= `RST_WR_PTR;
    end else if (wr_main) begin
      if (rq.index == `IDX_MAX_CODE) max_code_q <= rq.data;
      if (rq.index == `IDX_MARGIN) margin_q <= rq.data;
      if (rq.index == `IDX_WR_PTR) wr_ptr_q <= rq.data;
    end
  end

  // Shared configuration, writable from either space
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= `RST_ZERO;
    end else if ((wr_main || wr_pwr) && rq.index == `IDX_SHARED_CFG) begin
      cfg_q <= rq.data;
    end
  end

  // Power space thresholds and debounce settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dbc_clr_q     <= `RST_ZERO;
      dbc_set_q     <= `RST_ZERO;
      crit_thr_q    <= `RST_ZERO;
      warn_thr_q[0] <= `RST_ZERO;
      warn_thr_q[1] <= `RST_ZERO;
    end else if (wr_pwr) begin
      if (rq.index == `IDX_DBC_CLR) dbc_clr_q <= rq.data;
      if (rq.index == `IDX_DBC_SET) dbc_set_q <= rq.data;
      if (rq.index == `IDX_CRIT_THR) crit_thr_q <= rq.data;
      if (rq.index == `IDX_WARN1_THR) warn_thr_q[0] <= rq.data;
      if (rq.index == `IDX_WARN2_THR) warn_thr_q[1] <= rq.data;
    end
  end

  // Accepted voltage and state commands
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_code_q  <= `RST_ZERO;
      cur_state_q <= `RST_ZERO;
    end else begin
      if (volt_ok) cur_code_q <= rq.data;
      if (state_ok) cur_state_q <= rq.data;
    end
  end

  // Margin: sign-extend the offset and clamp to the code range
  logic [9:0] margin_sum;
  assign margin_sum = {2'b00, cur_code_q} + {{2{margin_q[7]}}, margin_q};

  // Ready drops on a zero code only when the config bit asks for it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      target_q <= 8'h00;
      ready_q  <= 1'b0;
    end else begin
      target_q <= margin_sum[9] ? 8'h00 : margin_sum[8] ? 8'hFF : margin_sum[7:0];
      if (!en_now) ready_q <= 1'b0;
      else if (zero_cmd && cfg_q[`CFG_READY_ZERO_BIT]) ready_q <= 1'b0;
      else if (en_rise || volt_ok) ready_q <= 1'b1;
    end
  end

  // Current limit trips, held at the top rather than wrapping
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cl_events_q <= `RST_ZERO;
    end else if (trip_edge && cl_events_q != `COUNT_MAX) begin
      cl_events_q <= cl_events_q + 8'h01;
    end
  end

  // Hot alert debounce: assert span on the way in, deassert span out
  logic        over_crit;
  logic [18:0] span_on;
  logic [18:0] span_off;
  assign over_crit = power_now > crit_thr_q;
  assign span_on   = me_span(dbc_set_q);
  assign span_off  = me_span(dbc_clr_q);

  always_comb begin
    hot_d = hot_q;
    case (hot_q)
      HOT_IDLE:     if (over_crit) hot_d = HOT_WAIT_ON;
      HOT_WAIT_ON:  if (!over_crit) hot_d = HOT_IDLE;
                    else if (dbc_cnt_q >= span_on) hot_d = HOT_ACTIVE;
      HOT_ACTIVE:   if (!over_crit) hot_d = HOT_WAIT_OFF;
      HOT_WAIT_OFF: if (over_crit) hot_d = HOT_ACTIVE;
                    else if (dbc_cnt_q >= span_off) hot_d = HOT_IDLE;
      default:      hot_d = HOT_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hot_q     <= HOT_IDLE;
      dbc_cnt_q <= 19'h00000;
      hot_n_q   <= 1'b1;
    end else begin
      hot_q     <= hot_d;
      hot_n_q   <= !(hot_d == HOT_ACTIVE || hot_d == HOT_WAIT_OFF);
      if (hot_d != hot_q) dbc_cnt_q <= 19'h00000;
      else if (tick && dbc_cnt_q != 19'h7FFFF) dbc_cnt_q <= dbc_cnt_q + 19'h00001;
    end
  end

  // Warning duration counters kept in mantissa/exponent form.
  // A mantissa step spans 2^exponent ticks,
  // keeping relative precision fixed over time.
  logic deep_state;
  assign deep_state = cur_state_q == `DEEPEST_STATE;

  for (genvar i = 0; i < 2; i++) begin : g_warn
    logic [15:0] sub_q;
    logic [3:0]  mant;
    logic [3:0]  expo;
    logic        run;
    logic        step;
    assign mant = warn_cnt_q[i][`ME_MANT_MSB:`ME_MANT_LSB];
    assign expo = warn_cnt_q[i][`ME_EXP_MSB:`ME_EXP_LSB];
    // Frozen while deepest, and stopped at the top code
    assign run  = tick && power_now > warn_thr_q[i] && !deep_state
                  && warn_cnt_q[i] != `ME_SATURATED;
    assign step = run && sub_q == (16'h0001 << expo) - 16'h0001;

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        sub_q         <= 16'h0000;
        warn_cnt_q[i] <= `RST_ZERO;
      end else if (cnt_clr[i]) begin
        sub_q         <= 16'h0000;
        warn_cnt_q[i] <= `RST_ZERO;
      end else if (step) begin
        sub_q <= 16'h0000;
        if (mant == 4'hF) warn_cnt_q[i] <= {`ME_MANT_WRAP, expo + 4'h1};
        else warn_cnt_q[i] <= {mant + 4'h1, expo};
      end else if (run) begin
        sub_q <= sub_q + 16'h0001;
      end
    end
  end

  assign hot_alert_n             = hot_n_q;
  assign regulator_ready         = ready_q;
  assign target_voltage_code     = target_q;
  assign deepest_low_power_state = deep_state;

endmodule

`default_nettype wire

// ==== verification/vr_slice_checker.sv ====
/* Checker: link handshake and ready pin.
   Sees only the slice's ports. */
`timescale 1ns/100ps
`default_nettype none
module vr_slice_checker (
  input wire logic                        mclk,             // Core clock
  input wire logic                        rst,              // Async reset
  input wire logic                        link_clk,         // Link clock
  input wire logic                        req_valid,        // Request offered
  input wire logic                        req_ready,        // Slice free
  input wire logic                        resp_valid,       // Answer pulse
  input wire vr_slice_pkg::link_resp_type resp,             // Answer fields
  input wire logic                        regulator_enable, // Enable pin
  input wire logic                        regulator_ready   // Ready pin
);
  import vr_slice_pkg::*;
  // Take, answer window, long enable drop
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    ##[3:10] resp_valid;
  endsequence
  sequence s_enable_low;
    !regulator_enable [*8];
  endsequence
  chk_answer_window: assert property (@(posedge link_clk) disable iff (rst) s_take |-> s_answer)
    else $error("answer late");
  chk_take_busy: assert property (@(posedge link_clk) disable iff (rst) s_take |=> !req_ready)
    else $error("not busy after take");
  chk_resp_pulse: assert property (@(posedge link_clk) disable iff (rst) resp_valid |=> !resp_valid)
    else $error("answer pulse too long");
  chk_resp_cause: assert property (@(posedge link_clk) disable iff (rst) resp_valid |-> !$past(req_ready))
    else $error("answer without request");
  chk_ready_rise: assert property (@(posedge link_clk) disable iff (rst) $rose(req_ready) |-> resp_valid)
    else $error("free before answer");
  chk_ready_answer: assert property (@(posedge link_clk) disable iff (rst) resp_valid |-> req_ready)
    else $error("busy at answer");
  chk_resp_hold: assert property (@(posedge link_clk) disable iff (rst) !resp_valid |-> $stable(resp))
    else $error("answer moved");
  chk_enable_drop: assert property (@(posedge mclk) disable iff (rst) s_enable_low |-> !regulator_ready)
    else $error("ready without enable");
endmodule

bind vr_reg_slice vr_slice_checker i_vr_slice_checker (.mclk(mclk), .rst(rst), .link_clk(link_clk),
  .req_valid(req_valid), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
  .regulator_enable(regulator_enable), .regulator_ready(regulator_ready));
`default_nettype wire

// ==== verification/vr_link_master.sv ====
/* Link master: one request at a time, gated 15 ns clock.
   Assumes answers within 12 link cycles. */
`timescale 1ns/100ps
`default_nettype none
module vr_link_master (
  input  wire logic                        rst,        // Keeps clock alive
  output logic                             link_clk,   // Gated link clock
  output logic                             req_valid,  // Request offered
  input  wire logic                        req_ready,  // Slice free
  output var vr_slice_pkg::link_req_type   req,        // Request fields
  input  wire logic                        resp_valid, // Answer pulse
  input  wire vr_slice_pkg::link_resp_type resp        // Answer fields
);
  import vr_slice_pkg::*;
  logic run;
  // Clock stands still low between frames, runs through reset
  initial begin
    run = 1'b0;
    link_clk = 1'b0;
    req_valid = 1'b0;
    req = '0;
    #3.3;
    forever begin
      #7.5;
      if (run || rst || link_clk) link_clk = ~link_clk;
    end
  end
  // Held until taken; released fields are inverted
  task automatic xfer(input req_kind_type k, input logic [3:0] a, input logic [7:0] i, input logic [7:0] d,
                      output link_resp_type rsp);
    run = 1'b1;
    rsp = 'x;
    @(negedge link_clk);
    while (req_ready !== 1'b1) @(negedge link_clk);
    req_valid = 1'b1;
    req = '{k, a, i, d};
    @(negedge link_clk);
    req_valid = 1'b0;
    req = link_req_type'(~req);
    for (int n = 0; n < 12 && resp_valid !== 1'b1; n++) @(negedge link_clk);
    if (resp_valid === 1'b1) rsp = resp;
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/voltage_reg_serial_regs_power_monitor_tb_top.sv ====
/* Bench: a register model predicts answers and pins.
   Assumes the link master and bound checker. */
`timescale 1ns/100ps
`default_nettype none
module voltage_reg_serial_regs_power_monitor_tb_top;
  import vr_slice_pkg::*;
  logic          mclk, rst, link_clk, req_valid, req_ready, resp_valid, current_limit_trip;
  logic          regulator_enable, hot_alert_n, regulator_ready, deepest_low_power_state;
  logic [7:0]    input_power_sense, target_voltage_code;
  logic [1:0]    cap_scale_strap;
  link_req_type  req;
  link_resp_type resp, r;
  int            mismatches, cmp_count, seed, cyc, n, k;
  int            m[int];
  int            mg[5] = '{1, 255, 254, 0, 0};
  int            rw[9] = '{12'h030, 12'h033, 12'h034, 12'h035, 12'hD49, 12'hD4A, 12'hD4B, 12'hD4C, 12'hD4F};
  // Short tick keeps spans short
  vr_reg_slice #(.TICK_CYCLES(4)) i_vr_reg_slice (.mclk, .rst, .link_clk, .req_valid, .req_ready, .req,
    .resp_valid, .resp, .input_power_sense, .current_limit_trip, .regulator_enable, .cap_scale_strap,
    .hot_alert_n, .regulator_ready, .target_voltage_code, .deepest_low_power_state);
  vr_link_master i_vr_link_master (.rst, .link_clk, .req_valid, .req_ready, .req, .resp_valid, .resp);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Watchdog far above the run's length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic check(input logic [7:0] got, input int exp, input string what);
    cmp_count++;
    if (got !== 8'(exp)) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, 8'(exp));
    end
  endtask
  // Model of each answer
  task automatic predict(input int k, a, i, d, output int ack, dat);
    int key;
    bit ro;
    key = a * 256 + i;
    ro = key inside {12'h02D, 12'h031, 12'h032, 12'h050, 12'h05C, 12'hD4D, 12'hD4E};
    ack = 0;
    dat = 0;
    if (k >= 2) begin
      if (a != 0) ack = 1;
      else if (k == 2 && d > m[12'h030]) ack = 2;
      else m[k == 2 ? 12'h031 : 12'h032] = d;
    end
    else if (!m.exists(key) || (k == 1 && ro)) ack = 1;
    else if (k == 1) m[key] = d;
    else dat = m[key];
  endtask
  task automatic op(input int k, a, i, d);
    int ea, ed;
    predict(k, a, i, d, ea, ed);
    i_vr_link_master.xfer(req_kind_type'(k), 4'(a), 8'(i), 8'(d), r);
    check({6'h00, r.ack}, ea, "ack");
    if (k == 0) check(r.data, ed, "data");
    tick(1);
  endtask
  task automatic wait_hot(input logic v);
    for (n = 0; n < 40 && hot_alert_n !== v; n++) tick(1);
    check({7'h00, hot_alert_n}, v, "hot alert");
  endtask
  initial begin
    seed = 76;
    rst = 1'b1;
    input_power_sense = 8'h00;
    current_limit_trip = 1'b0;
    regulator_enable = 1'b1;
    cap_scale_strap = {1'b0, 1'($random(seed))};
    m = '{12'h02D: 8'hCA, 12'h030: 8'hFF, 12'h031: 0, 12'h032: 0, 12'h033: 0, 12'h034: 0, 12'h035: 8'h35,
          12'h050: cap_scale_strap, 12'h05C: 0, 12'hD34: 0, 12'hD49: 0, 12'hD4A: 0, 12'hD4B: 0,
          12'hD4C: 0, 12'hD4D: 0, 12'hD4E: 0, 12'hD4F: 0};
    tick(2);
    rst = 1'b0;
    tick(8);
    // Resets, refusals, random read-back
    foreach (m[key]) op(0, key >> 8, key & 255, 0);
    op(1, 0, 8'h2D, 8'h00);
    op(1, 0, 8'h31, 8'h12);
    op(0, 0, 8'h4A, 0);
    op(0, 4'hD, 8'h30, 0);
    op(0, 0, 8'h40, 0);
    foreach (rw[j]) begin
      op(1, rw[j] >> 8, rw[j] & 255, $random(seed) & 255);
      op(0, rw[j] >> 8, rw[j] & 255, 0);
    end
    $display("test registers ended");
    // Max code, margin, ready, states, trips
    op(1, 0, 8'h30, 8'h80);
    op(2, 0, 0, 8'h81);
    op(2, 0, 0, 8'h80);
    op(0, 0, 8'h31, 0);
    mg[4] = $random(seed) & 255;
    foreach (mg[j]) begin
      op(1, 0, 8'h33, mg[j]);
      tick(8);
      check(target_voltage_code, 128 + $signed(8'(mg[j])), "target");
    end
    check({7'h00, regulator_ready}, 1, "ready");
    op(1, 0, 8'h34, 8'h01);
    op(2, 0, 0, 8'h00);
    tick(6);
    check({7'h00, regulator_ready}, 0, "ready");
    op(2, 0, 0, 8'h40);
    tick(6);
    check({7'h00, regulator_ready}, 1, "ready");
    regulator_enable = 1'b0;
    tick(12);
    check({7'h00, regulator_ready}, 0, "ready");
    regulator_enable = 1'b1;
    for (k = 4; k >= 0; k--) begin
      op(3, 0, 0, k);
      op(0, 0, 8'h32, 0);
      check({7'h00, deepest_low_power_state}, k == 4, "deepest");
    end
    k = 1 + ($random(seed) & 3);
    repeat (k) begin
      current_limit_trip = 1'b1;
      tick(8);
      current_limit_trip = 1'b0;
      tick(8);
    end
    m[12'h05C] += k;
    op(0, 0, 8'h5C, 0);
    $display("test voltage ended");
    // Hot alert, warning count, clear, hold
    op(1, 4'hD, 8'h49, 8'h00);
    op(1, 4'hD, 8'h4A, 8'h80);
    op(1, 4'hD, 8'h4B, 8'h40);
    op(1, 4'hD, 8'h4F, 8'h12);
    input_power_sense = 8'h90;
    tick(10);
    check({7'h00, hot_alert_n}, 1, "hot early");
    wait_hot(0);
    input_power_sense = 8'h00;
    wait_hot(1);
    i_vr_link_master.xfer(REQ_GET, 4'hD, 8'h4D, 8'h00, r);
    cmp_count++;
    if ((r.data > 8'h00) !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: warning count empty", $time);
    end
    op(0, 4'hD, 8'h4D, 0);
    op(3, 0, 0, 8'h04);
    input_power_sense = 8'h90;
    tick(60);
    input_power_sense = 8'h00;
    op(0, 4'hD, 8'h4D, 0);
    op(3, 0, 0, 0);
    $display("test power ended");
    close_out();
  end
endmodule
`default_nettype wire
